// [nvram_host_pkg.sv]
// package for the bytewide battery-backed sram/clock host controller
// assumes a 40 mhz mclk and a classic wishbone register port
package nvram_host_pkg;

    // clock period and documented access times, in ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int ADDRESS_ACCESS_TIME_FAST = 70;
    localparam int ADDRESS_ACCESS_TIME_SLOW = 85;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_FAST = 25;
    localparam int OUTPUT_ENABLE_ACCESS_TIME_SLOW = 35;
    localparam int SELECT_RELEASE_TIME_FAST = 20;
    localparam int SELECT_RELEASE_TIME_SLOW = 25;
    localparam int WRITE_PULSE_TIME_FAST = 45;
    localparam int WRITE_PULSE_TIME_SLOW = 55;
    localparam int WRITE_DATA_SETUP_FAST = 25;
    localparam int WRITE_DATA_SETUP_SLOW = 30;
    localparam int STROBE_RECOVERY_TIME = 0;

    // least times round up, never below one cycle
    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] READ_CYC_FAST = CNT_W'(ceil_cycles(max2(
        ADDRESS_ACCESS_TIME_FAST, OUTPUT_ENABLE_ACCESS_TIME_FAST)));
    localparam logic [CNT_W-1:0] READ_CYC_SLOW = CNT_W'(ceil_cycles(max2(
        ADDRESS_ACCESS_TIME_SLOW, OUTPUT_ENABLE_ACCESS_TIME_SLOW)));
    localparam logic [CNT_W-1:0] RELEASE_CYC_FAST = CNT_W'(ceil_cycles(SELECT_RELEASE_TIME_FAST));
    localparam logic [CNT_W-1:0] RELEASE_CYC_SLOW = CNT_W'(ceil_cycles(SELECT_RELEASE_TIME_SLOW));
    localparam logic [CNT_W-1:0] WPULSE_CYC_FAST = CNT_W'(ceil_cycles(max2(
        WRITE_PULSE_TIME_FAST, WRITE_DATA_SETUP_FAST)));
    localparam logic [CNT_W-1:0] WPULSE_CYC_SLOW = CNT_W'(ceil_cycles(max2(
        WRITE_PULSE_TIME_SLOW, WRITE_DATA_SETUP_SLOW)));
    localparam logic [CNT_W-1:0] RECOVERY_CYC = CNT_W'(ceil_cycles(STROBE_RECOVERY_TIME));
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // device memory map
    localparam int ADDR_W = 17;
    localparam logic [ADDR_W-1:0] CLOCK_CONTROL_BYTE = 17'h1FFF8;
    localparam logic [ADDR_W-1:0] CLOCK_BYTES_LOW = 17'h1FFF9;
    localparam logic [ADDR_W-1:0] CLOCK_BYTES_HIGH = 17'h1FFFF;

    // wishbone register byte offsets
    localparam logic [3:0] REG_ADDRESS = 4'h0;
    localparam logic [3:0] REG_WRITE_DATA = 4'h4;
    localparam logic [3:0] REG_COMMAND = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // command register bits
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int CMD_SLOW_BIT = 2;
    // status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_SLOW_BIT = 2;
    localparam int STAT_RDATA_LSB = 8;

    typedef enum {ST_IDLE, ST_RD_ACCESS, ST_RD_RELEASE, ST_WR_SETUP, ST_WR_PULSE,
        ST_WR_HOLD, ST_WR_RECOVER} phase_t;

    // pins toward the device; dqOe is low while the host drives
    typedef struct packed {
        logic ceN;
        logic oeN;
        logic weN;
        logic [ADDR_W-1:0] addr;
        logic [7:0] dqOut;
        logic dqOe;
    } sram_pins_t;

    localparam sram_pins_t PINS_IDLE = '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1,
        addr: '0, dqOut: 8'h00, dqOe: 1'b1};

endpackage

// [nvram_host.sv]
// host controller driving a bytewide battery-backed sram with clock bytes
// assumes pins synchronous to mclk, a classic wishbone master for software
// Functional notes
// RL1 - device keeps date and time as bcd bytes, 24-hour clock
// RL2 - device calendar handles all month lengths and leap years to 2100
// RL3 - byte 1FFF8h is the clock control byte, gating access and calibration
// RL4 - clock bytes 1FFFFh..1FFF9h are plain array cells, not the counters
// RL5 - device copies its counters into the clock bytes once per second
// RL6 - clock bytes use the same read and write cycles as any memory
// RL7 - device blocks all writes while power-fail is detected
// RL8 - write strobe high and select low means read
// RL9 - seventeen address lines pick one of 131,072 bytes
// RL10 - device drives data only while select and output enable are low
// RL11 - read data valid after latest of address, select, enable access times
// RL12 - data indeterminate until address access time even if outputs on
// RL13 - old data held briefly after address change, then indeterminate
// RL14 - device releases data within 20 or 25 ns after deselect
// RL15 - write entered when strobe and select low with address stable
// RL16 - write starts at later falling edge, ends at earlier rising edge
// RL17 - host holds address stable through the whole write
// RL18 - host returns select or strobe high for recovery before next cycle
// RL19 - host gives write data setup before write end and hold after
// RL20 - host keeps output enable high during writes
// RL21 - strobe fall turns outputs off if they were already on
// RL22 - power-fail input forces deselect, outputs off, controls ignored
`timescale 1ns/100ps
`default_nettype none

module nvram_host
    import nvram_host_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // device pins
    output nvram_host_pkg::sram_pins_t pins,
    input wire logic [7:0] dqIn
);
    import nvram_host_pkg::*;

    typedef struct packed {
        phase_t phase;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] address;
        logic [7:0] writeData;
        logic [7:0] readData;
        logic slowGrade;
        logic opWrite;
        logic done;
        logic ack;
        logic [31:0] rdat;
        sram_pins_t pins;
    } state_t;

    localparam state_t STATE_RESET = '{phase: ST_IDLE, cnt: '0, address: '0,
        writeData: 8'h00, readData: 8'h00, slowGrade: 1'b0, opWrite: 1'b0,
        done: 1'b0, ack: 1'b0, rdat: 32'h0000_0000, pins: PINS_IDLE};

    state_t st;
    state_t next_st;

    // byte-lane merge of a wishbone write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
        input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic request;
    logic busy;
    logic [31:0] statusWord;
    logic [31:0] merged;

    assign request = wb_cyc_i && wb_stb_i && !st.ack;
    assign busy = (st.phase != ST_IDLE);

    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[STAT_BUSY_BIT] = busy;
        statusWord[STAT_DONE_BIT] = st.done;
        statusWord[STAT_SLOW_BIT] = st.slowGrade;
        statusWord[STAT_RDATA_LSB +: 8] = st.readData;
    end

    always_comb begin
        next_st = st;
        next_st.ack = request;
        merged = 32'h0000_0000;

        // register port: one wait state, unmapped reads give zero
        if (request) begin
            if (wb_adr_i == REG_ADDRESS) begin
                merged = merge(32'(st.address), wb_dat_i, wb_sel_i);
                next_st.rdat = 32'(st.address);
                if (wb_we_i && !busy) begin
                    next_st.address = merged[ADDR_W-1:0];
                end
            end else if (wb_adr_i == REG_WRITE_DATA) begin
                merged = merge(32'(st.writeData), wb_dat_i, wb_sel_i);
                next_st.rdat = 32'(st.writeData);
                if (wb_we_i && !busy) begin
                    next_st.writeData = merged[7:0];
                end
            end else if (wb_adr_i == REG_COMMAND) begin
                next_st.rdat = 32'h0000_0000;
                // a command while busy is dropped so the pins never glitch mid-cycle
                if (wb_we_i && wb_sel_i[0] && !busy) begin
                    next_st.slowGrade = wb_dat_i[CMD_SLOW_BIT];
                    if (wb_dat_i[CMD_GO_BIT]) begin
                        next_st.done = 1'b0;
                        next_st.opWrite = wb_dat_i[CMD_WRITE_BIT];
                        // clock bytes and control byte take the same cycles RL6
                        next_st.pins.addr = st.address;
                        if (wb_dat_i[CMD_WRITE_BIT]) begin
                            // address settles with strobes high, oe held high RL20
                            next_st.phase = ST_WR_SETUP;
                            next_st.pins.dqOut = st.writeData;
                            next_st.pins.dqOe = 1'b0;
                            next_st.pins.oeN = 1'b1;
                        end else begin
                            // read: strobe high, select and enable low RL8
                            next_st.phase = ST_RD_ACCESS;
                            next_st.pins.ceN = 1'b0;
                            next_st.pins.oeN = 1'b0;
                            next_st.pins.weN = 1'b1;
                            next_st.cnt = (wb_dat_i[CMD_SLOW_BIT] ? READ_CYC_SLOW :
                                READ_CYC_FAST) - CNT_ONE;
                        end
                    end
                end
            end else if (wb_adr_i == REG_STATUS) begin
                next_st.rdat = statusWord;
            end else begin
                next_st.rdat = 32'h0000_0000;
            end
        end

        case (st.phase)
            ST_IDLE: begin
            end
            ST_RD_ACCESS: begin
                // sample only once the slowest access time has passed RL11 RL12
                if (st.cnt == '0) begin
                    next_st.readData = dqIn;
                    next_st.pins.ceN = 1'b1;
                    next_st.pins.oeN = 1'b1;
                    next_st.phase = ST_RD_RELEASE;
                    next_st.cnt = (st.slowGrade ? RELEASE_CYC_SLOW : RELEASE_CYC_FAST) - CNT_ONE;
                end else begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end
            end
            ST_RD_RELEASE: begin
                // let the device float the bus before we may drive it RL14
                if (st.cnt == '0) begin
                    next_st.phase = ST_IDLE;
                    next_st.done = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end
            end
            ST_WR_SETUP: begin
                // both strobes fall together after the address is stable RL15 RL16
                next_st.pins.ceN = 1'b0;
                next_st.pins.weN = 1'b0;
                next_st.phase = ST_WR_PULSE;
                next_st.cnt = (st.slowGrade ? WPULSE_CYC_SLOW : WPULSE_CYC_FAST) - CNT_ONE;
            end
            ST_WR_PULSE: begin
                // pulse covers both the strobe width and the data setup RL19
                if (st.cnt == '0) begin
                    next_st.pins.ceN = 1'b1;
                    next_st.pins.weN = 1'b1;
                    next_st.phase = ST_WR_HOLD;
                end else begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end
            end
            ST_WR_HOLD: begin
                // data and address stay one cycle past the rising strobes RL17 RL19
                next_st.pins.dqOe = 1'b1;
                next_st.phase = ST_WR_RECOVER;
                next_st.cnt = RECOVERY_CYC - CNT_ONE;
            end
            ST_WR_RECOVER: begin
                // strobes stay high before the next cycle may start RL18
                if (st.cnt == '0) begin
                    next_st.phase = ST_IDLE;
                    next_st.done = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - CNT_ONE;
                end
            end
            default: begin
                next_st = STATE_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdat;
    assign pins = st.pins;

endmodule

`default_nettype wire

// [nvram_host_chk.sv]
// checker for nvram_host: wishbone answer and device pin sequencing
// assumes one clock domain and the async active-low reset
`timescale 1ns/100ps
`default_nettype none
module nvram_host_chk
    import nvram_host_pkg::*;
(
    // clock, reset and wishbone
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // device pins
    input wire nvram_host_pkg::sram_pins_t pins,
    input wire logic [7:0] dqIn
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_addr_held: assert property ((!pins.ceN || !pins.dqOe) && $past(!pins.ceN || !pins.dqOe)
        |-> $stable(pins.addr))
        else $error("address moved");
    a_oe_off_write: assert property (!pins.weN || !pins.dqOe |-> pins.oeN)
        else $error("oe low in write");
    a_select_recovery: assert property ($rose(pins.ceN) |=> pins.ceN)
        else $error("no recovery");
    a_data_setup: assert property ($fell(pins.weN) |-> $past(!pins.dqOe))
        else $error("data late");
    a_data_hold: assert property ($rose(pins.weN) |-> !pins.dqOe && $stable(pins.dqOut))
        else $error("data not held");
    a_write_pulse: assert property ($fell(pins.weN) |-> (!pins.weN && !pins.ceN)[*2])
        else $error("short write");
    a_read_access: assert property ($fell(pins.oeN) |-> (!pins.oeN && !pins.ceN && pins.weN)[*3])
        else $error("short read");
    c_write: cover property ($rose(pins.weN));
    c_read: cover property ($rose(pins.oeN));
    c_ack: cover property (wb_ack_o && !wb_we_i);
endmodule
bind nvram_host nvram_host_chk nvram_host_chk_inst (.*);
`default_nettype wire

// [nvram_dev_model.sv]
// behavioural model of the bytewide battery-backed ram with clock bytes
// assumes pins change on mclk; pwrFail stands in for a failing supply
`timescale 1ns/100ps
`default_nettype none
module nvram_dev_model
    import nvram_host_pkg::*;
(
    // host side
    input wire logic mclk,
    input wire nvram_host_pkg::sram_pins_t pins,
    input wire logic pwrFail,
    // data toward host
    output logic [7:0] dqIn
);
    // the counters behind the clock bytes are not modelled: a run is far shorter than
    // the once-per-second copy, so those bytes only hold what the host wrote
    localparam int RD_VALID_NS = max2(ADDRESS_ACCESS_TIME_FAST, OUTPUT_ENABLE_ACCESS_TIME_FAST);
    logic [7:0] mem [logic [ADDR_W-1:0]];
    logic [7:0] idle = 8'h5A;
    logic [ADDR_W-1:0] rdAddr = '0;
    logic wrArmed = 1'b0;
    int rdAge = 0;
    wire logic wrOn = !pins.ceN && !pins.weN && !pwrFail;
    wire logic rdOn = !pins.ceN && !pins.oeN && pins.weN && !pwrFail;
    // data is only good once the access has lasted the fast grade's worst time
    wire logic rdValid = (rdAge + 1) * CLK_PERIOD_NS >= RD_VALID_NS;
    // released bus wanders so a stale value is never mistaken for data
    always @(posedge mclk) begin
        idle <= ~idle + 8'h01;
        rdAddr <= pins.addr;
        // a moved address restarts the access
        rdAge <= !rdOn ? 0 : (pins.addr != rdAddr) ? 1 : rdAge + 1;
    end
    // a write lands when select or strobe first rises; an undriven bus stores garbage
    always @(wrOn) begin
        if (wrOn === 1'b1) begin
            wrArmed = 1'b1;
        end else if (wrArmed) begin
            if (!pwrFail) begin
                mem[pins.addr] = pins.dqOe ? ~pins.dqOut : pins.dqOut;
            end
            wrArmed = 1'b0;
        end
    end
    always_comb begin
        if (!rdOn) begin
            dqIn = idle;
        end else if (!rdValid) begin
            dqIn = ~idle;
        end else begin
            dqIn = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
        end
    end
endmodule
`default_nettype wire

// [nvram_host_tb.sv]
// testbench: software view of nvram_host against the device model
// assumes nvram_dev_model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module nvram_host_tb;
    import nvram_host_pkg::*;
    logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, pwrFail = 0, ack;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, datO;
    logic [7:0] dqIn;
    logic [7:0] shadow [int];
    sram_pins_t pins;
    int err_count = 0, tests_run = 0;
    nvram_host nvram_host_inst (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(datO),
        .wb_ack_o(ack), .pins(pins), .dqIn(dqIn));
    nvram_dev_model nvram_dev_model_inst (.mclk(mclk), .pins(pins), .pwrFail(pwrFail),
        .dqIn(dqIn));
    initial forever #12.5 mclk = ~mclk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_count++;
            complete_run();
        end
        rdat = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    endtask
    function automatic logic [7:0] expByte(input int a);
        return shadow.exists(a) ? shadow[a] : 8'hFF;
    endfunction
    task automatic op(input logic [16:0] a, input logic w, input logic [7:0] d, input logic sl);
        int n;
        wb(REG_ADDRESS, 1'b1, {15'h0, a});
        wb(REG_WRITE_DATA, 1'b1, {24'h0, d});
        wb(REG_COMMAND, 1'b1, {29'h0, sl, w, 1'b1});
        n = 0;
        do begin
            wb(REG_STATUS, 1'b0, 32'h0);
            n++;
        end while (rdat[STAT_BUSY_BIT] !== 1'b0 && n < 10);
        if (rdat[STAT_BUSY_BIT] !== 1'b0) begin
            err_count++;
            complete_run();
        end
        chk("status", {29'h0, sl, 2'h2}, {29'h0, rdat[2:0]});
        if (w && !pwrFail)
            shadow[a] = d;
        if (!w)
            chk("readbyte", {24'h0, expByte(a)}, {24'h0, rdat[STAT_RDATA_LSB +: 8]});
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        complete_run();
    end
    initial begin
        int a;
        void'($urandom(39));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk("idlepins", {3'h0, PINS_IDLE}, {3'h0, pins});
        wb(4'h2, 1'b0, 32'h0);
        chk("unmapped", 32'h0, rdat);
        for (a = 17'h1FFF8; a <= 17'h1FFFF; a++) begin
            op(17'(a), 1'b1, 8'(a * 29), a[0]);
            op(17'(a), 1'b0, 8'h00, ~a[0]);
        end
        repeat (40) begin
            a = $urandom_range(17'h1FFFF);
            op(17'(a), 1'b1, 8'($urandom), 1'($urandom));
            op(17'(a), 1'b0, 8'h00, 1'($urandom));
        end
        pwrFail <= 1'b1;
        op(17'h00123, 1'b1, 8'h3C, 1'b0);
        pwrFail <= 1'b0;
        op(17'h00123, 1'b0, 8'h00, 1'b0);
        // an address write while a slow write runs must be dropped
        wb(REG_ADDRESS, 1'b1, 32'h00000055);
        wb(REG_COMMAND, 1'b1, 32'h00000007);
        wb(REG_ADDRESS, 1'b1, 32'h00000AAA);
        wb(REG_ADDRESS, 1'b0, 32'h0);
        chk("busyaddr", 32'h00000055, rdat);
        repeat (8) @(posedge mclk);
        shadow[32'h55] = 8'h00;
        op(17'h00055, 1'b0, 8'h00, 1'b1);
        // register readback: address is cut to its width, command reads zero
        wb(REG_ADDRESS, 1'b1, 32'hFFFF_FFFF);
        wb(REG_ADDRESS, 1'b0, 32'h0);
        chk("addrwidth", 32'h0001_FFFF, rdat);
        wb(REG_WRITE_DATA, 1'b1, 32'hFFFF_FFA5);
        wb(REG_WRITE_DATA, 1'b0, 32'h0);
        chk("wdata", 32'h0000_00A5, rdat);
        wb(REG_COMMAND, 1'b0, 32'h0);
        chk("cmdread", 32'h0, rdat);
        complete_run();
    end
endmodule
`default_nettype wire
